// file: hdl/elt_line_trigger.sv
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`include "elt_cfg.svh"
module elt_line_trigger #(
    parameter int IW        = 32,
    parameter int MW        = 32,
    parameter int AVG_LOG2  = 4
) (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // wishbone slave
    input  wire logic                    cyc_i,
    input  wire logic                    stb_i,
    input  wire logic                    we_i,
    input  wire logic [7:0]              adr_i,
    input  wire logic [3:0]              sel_i,
    input  wire logic [31:0]             dat_i,
    output logic      [31:0]             dat_o,
    output logic                         ack_o,
    // encoder
    input  wire logic                    quad_channel_a_i,
    input  wire logic                    quad_channel_b_i,
    // line trigger
    output logic                         line_trigger_o,
    output logic                         direction_o
);
    import elt_pkg::*;

    generate
        if (IW < 16 || IW > 32 || MW < 1 || MW > 32) begin : g_chk
            $error("elt_line_trigger: unsupported width");
        end
        if (AVG_LOG2 < 1 || AVG_LOG2 > 7) begin : g_chk_avg
            $error("elt_line_trigger: averaging depth out of range");
        end
    endgenerate

    // registers
    logic                 method_q;
    logic [1:0]           policy_q;
    logic                 sense_q;
    logic [31:0]          divider_q;
    logic [15:0]          pass_q;
    logic [2:0]           avg_q;
    logic [31:0]          maxint_q;
    logic [7:0]           strobe_q;
    logic                 begin_pulse;
    logic                 wr_en;
    logic [31:0]          wmask;
    logic                 rd_take;

    assign wr_en = cyc_i && stb_i && we_i && !ack_o;
    assign rd_take = cyc_i && stb_i && !we_i && !ack_o;
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    // capture begin is a self-clearing command bit
    assign begin_pulse = wr_en && (adr_i == `ELT_OFS_CTRL) && sel_i[0]
                         && dat_i[`ELT_CTRL_BEGIN];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            method_q  <= 1'b0;
            policy_q  <= 2'h0;
            sense_q   <= 1'b0;
            divider_q <= `ELT_RST_DIVIDER;
            pass_q    <= `ELT_RST_PASS;
            avg_q     <= `ELT_RST_AVG;
            maxint_q  <= `ELT_RST_MAXINT;
            strobe_q  <= `ELT_RST_STROBE;
        end else if (wr_en) begin
            case (adr_i)
                `ELT_OFS_CTRL: begin
                    if (sel_i[0]) begin
                        method_q <= dat_i[`ELT_CTRL_METHOD];
                        policy_q <= dat_i[`ELT_CTRL_POL_HI:`ELT_CTRL_POL_LO];
                        sense_q  <= dat_i[`ELT_CTRL_SENSE];
                    end
                end
                `ELT_OFS_DIVIDER: divider_q <= (divider_q & ~wmask) | (dat_i & wmask);
                `ELT_OFS_PASS: begin
                    if (sel_i[0]) pass_q[7:0]  <= dat_i[7:0];
                    if (sel_i[1]) pass_q[15:8] <= dat_i[15:8];
                end
                `ELT_OFS_AVG: begin
                    if (sel_i[0]) avg_q <= dat_i[2:0];
                end
                `ELT_OFS_MAXINT: maxint_q <= (maxint_q & ~wmask) | (dat_i & wmask);
                `ELT_OFS_STROBE: begin
                    // zero would never end the strobe, so it is held at the shortest length
                    if (sel_i[0]) strobe_q <= (dat_i[7:0] == 8'h00) ? 8'h01 : dat_i[7:0];
                end
                default: ;
            endcase
        end
    end

    // encoder edges and direction
    logic                 a_q;
    logic                 b_q;
    logic                 a_rise;
    logic                 any_edge;
    logic                 raw_fwd_q;
    logic                 dir_pos;
    logic                 dir_now_pos;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
        end else begin
            a_q <= quad_channel_a_i;
            b_q <= quad_channel_b_i;
        end
    end

    assign a_rise   = quad_channel_a_i && !a_q;
    assign any_edge = (quad_channel_a_i ^ a_q) || (quad_channel_b_i ^ b_q);

    // a change of A against old B, or of B against new A, shows who leads
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            raw_fwd_q <= 1'b1;
        end else if (any_edge) begin
            raw_fwd_q <= quad_channel_a_i ^ b_q;
        end
    end

    assign dir_pos     = raw_fwd_q ^ sense_q;
    assign direction_o = dir_pos;

    // the edge that turns the travel is judged by its own direction, not the last one
    always_comb begin
        if (any_edge) begin
            dir_now_pos = (quad_channel_a_i ^ b_q) ^ sense_q;
        end else begin
            dir_now_pos = dir_pos;
        end
    end

    // interval measurement
    logic [IW-1:0]        ivl_cnt_q;
    logic [IW-1:0]        ivl_clip;
    logic [IW-1:0]        ivl_mean;
    logic                 have_ivl_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ivl_cnt_q  <= '0;
            have_ivl_q <= 1'b0;
        end else if (a_rise) begin
            ivl_cnt_q  <= IW'(1);
            have_ivl_q <= 1'b1;
        end else if (ivl_cnt_q != '1) begin
            ivl_cnt_q  <= ivl_cnt_q + 1'b1;
        end
    end

    // a stopped belt would stretch the period for ever; the limit caps it
    always_comb begin
        ivl_clip = ivl_cnt_q;
        if (maxint_q != 32'h0 && 32'(ivl_cnt_q) > maxint_q) begin
            ivl_clip = IW'(maxint_q);
        end
    end

    elt_interval_avg #(
        .W        (IW),
        .LOG2_MAX (AVG_LOG2)
    ) u_avg (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .push_i       (a_rise && have_ivl_q),
        .sample_i     (ivl_clip),
        .depth_log2_i (avg_q),
        .mean_o       (ivl_mean)
    );

    // ratio divider
    logic                 decimate;
    logic [15:0]          dec_cnt_q;
    logic                 dec_fire;
    logic [IW+31:0]       thresh;
    logic [IW+31:0]       phase_q;
    logic [32:0]          credit_q;
    logic                 interp_fire;

    assign decimate = (divider_q[15:0] == 16'h0);
    assign dec_fire = a_rise && (dec_cnt_q >= divider_q[31:16] - 16'h1);
    assign thresh   = (IW+32)'(ivl_mean) * (IW+32)'(divider_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec_cnt_q <= '0;
        end else if (!decimate || method_q) begin
            dec_cnt_q <= '0;
        end else if (a_rise) begin
            dec_cnt_q <= dec_fire ? 16'h0 : dec_cnt_q + 16'h1;
        end
    end

    // each A pulse earns 65536 of credit and each trigger spends the divider,
    // so the long-run ratio is exact even when the timer runs ahead
    assign interp_fire = !decimate && have_ivl_q && (phase_q >= thresh)
                         && (credit_q >= 33'(divider_q)) && (ivl_mean != '0);

    always_ff @(posedge clk_i) begin
        if (rst_i || decimate || method_q) begin
            phase_q  <= '0;
            credit_q <= '0;
        end else begin
            if (interp_fire) begin
                phase_q <= phase_q + (IW+32)'(`ELT_RATIO_SCALE) - thresh;
            end else if (phase_q < thresh) begin
                phase_q <= phase_q + (IW+32)'(`ELT_RATIO_SCALE);
            end
            case ({a_rise, interp_fire})
                2'b10: credit_q <= credit_q + 33'(`ELT_RATIO_SCALE);
                2'b01: credit_q <= credit_q - 33'(divider_q);
                2'b11: credit_q <= credit_q + 33'(`ELT_RATIO_SCALE) - 33'(divider_q);
                default: ;
            endcase
        end
    end

    // edge skip
    logic [15:0]          skip_cnt_q;
    logic                 skip_fire;

    assign skip_fire = any_edge && (skip_cnt_q >= pass_q);

    always_ff @(posedge clk_i) begin
        if (rst_i || !method_q) begin
            skip_cnt_q <= '0;
        end else if (any_edge) begin
            skip_cnt_q <= skip_fire ? 16'h0 : skip_cnt_q + 16'h1;
        end
    end

    // direction mask
    logic                 gen_pulse;
    logic                 masking;
    logic                 with_dir;
    logic [MW-1:0]        mask_cnt_q;
    logic                 issue;

    // only one method feeds the mask at a time
    assign gen_pulse = (method_q == ELT_EDGE_SKIP) ? skip_fire
                       : (decimate ? dec_fire : interp_fire);
    assign masking   = (policy_q == ELT_FORWARD_ONLY) || (policy_q == ELT_REVERSE_ONLY);
    assign with_dir  = (policy_q == ELT_FORWARD_ONLY) ? dir_now_pos : !dir_now_pos;

    // a capture begin in the same cycle as a pulse wins, so the count starts clean
    always_ff @(posedge clk_i) begin
        if (rst_i || begin_pulse) begin
            mask_cnt_q <= '0;
        end else if (gen_pulse && masking) begin
            if (!with_dir) begin
                if (mask_cnt_q != '1) mask_cnt_q <= mask_cnt_q + 1'b1;
            end else if (mask_cnt_q != '0) begin
                mask_cnt_q <= mask_cnt_q - 1'b1;
            end
        end
    end

    // the pulse that brings the count to zero is still held back
    assign issue = gen_pulse && (!masking || (with_dir && mask_cnt_q == '0));

    // strobe stretch
    logic [3:0]           unit_cnt_q;
    logic                 unit_tick;
    logic [7:0]           strobe_cnt_q;

    // one strobe unit is two clocks; each trigger restarts it so the first unit is whole
    assign unit_tick = (unit_cnt_q == 4'(`ELT_STROBE_UNIT_CYC - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i || issue) begin
            unit_cnt_q <= '0;
        end else begin
            unit_cnt_q <= unit_tick ? 4'h0 : unit_cnt_q + 4'h1;
        end
    end

    // a new trigger during a strobe restarts it, so overlapping triggers merge into one longer strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strobe_cnt_q   <= '0;
            line_trigger_o <= 1'b0;
        end else if (issue) begin
            strobe_cnt_q   <= strobe_q;
            line_trigger_o <= 1'b1;
        end else if (unit_tick && strobe_cnt_q != 8'h0) begin
            strobe_cnt_q   <= strobe_cnt_q - 8'h1;
            line_trigger_o <= (strobe_cnt_q != 8'h1);
        end
    end

    // bus read and ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= '0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            if (rd_take) begin
                case (adr_i)
                    `ELT_OFS_CTRL:    dat_o <= {28'h0, sense_q, policy_q, method_q};
                    `ELT_OFS_DIVIDER: dat_o <= divider_q;
                    `ELT_OFS_PASS:    dat_o <= {16'h0, pass_q};
                    `ELT_OFS_AVG:     dat_o <= {29'h0, avg_q};
                    `ELT_OFS_MAXINT:  dat_o <= maxint_q;
                    `ELT_OFS_STROBE:  dat_o <= {24'h0, strobe_q};
                    `ELT_OFS_STATUS:  dat_o <= {29'h0, masking && mask_cnt_q != '0,
                                                raw_fwd_q, dir_pos};
                    `ELT_OFS_MASKCNT: dat_o <= 32'(mask_cnt_q);
                    default:          dat_o <= 32'h0;
                endcase
            end
        end
    end
endmodule

// file: hdl/elt_cfg.svh
`ifndef ELT_CFG_SVH
`define ELT_CFG_SVH

// register byte offsets
`define ELT_OFS_CTRL       8'h00
`define ELT_OFS_DIVIDER    8'h04
`define ELT_OFS_PASS       8'h08
`define ELT_OFS_AVG        8'h0c
`define ELT_OFS_MAXINT     8'h10
`define ELT_OFS_STROBE     8'h14
`define ELT_OFS_STATUS     8'h18
`define ELT_OFS_MASKCNT    8'h1c

// control register fields
`define ELT_CTRL_METHOD    0
`define ELT_CTRL_POL_LO    1
`define ELT_CTRL_POL_HI    2
`define ELT_CTRL_SENSE     3
`define ELT_CTRL_BEGIN     4

// reset values
`define ELT_RST_DIVIDER    32'h0001_0000
`define ELT_RST_PASS       16'h0000
`define ELT_RST_AVG        3'h0
`define ELT_RST_MAXINT     32'h0000_0000
`define ELT_RST_STROBE     8'h01

// ratio scale: triggers per pulse = scale / divider
`define ELT_RATIO_SCALE    32'h0001_0000

// timing
`define ELT_CLK_PERIOD_PS  5000
`define ELT_STROBE_UNIT_NS 10
`define ELT_STROBE_UNIT_CYC ((`ELT_STROBE_UNIT_NS * 1000) / `ELT_CLK_PERIOD_PS)

`endif

// file: hdl/elt_pkg.sv
package elt_pkg;

    typedef enum logic {
        ELT_RATIO_DIVIDER,
        ELT_EDGE_SKIP
    } elt_method_t;

    typedef enum logic [1:0] {
        ELT_MOTION,
        ELT_FORWARD_ONLY,
        ELT_REVERSE_ONLY,
        ELT_POLICY_RSVD
    } elt_policy_t;

    typedef enum logic [1:0] {
        ELT_ST_PASS,
        ELT_ST_REVERSE,
        ELT_ST_RETURN
    } elt_mask_state_t;

endpackage

// file: hdl/elt_interval_avg.sv
`timescale 1ns/100ps
// keeps the last intervals and gives the mean of the newest 2**depth of them
module elt_interval_avg #(
    parameter int W         = 32,
    parameter int LOG2_MAX  = 4
) (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // sample side
    input  wire logic                    push_i,
    input  wire logic [W-1:0]            sample_i,
    input  wire logic [2:0]              depth_log2_i,
    // mean
    output logic      [W-1:0]            mean_o
);
    localparam int DEPTH = 1 << LOG2_MAX;

    generate
        if (LOG2_MAX < 1 || LOG2_MAX > 7) begin : g_chk
            $error("elt_interval_avg: LOG2_MAX out of range");
        end
    endgenerate

    logic [W-1:0]             mem_q [DEPTH];
    logic [LOG2_MAX-1:0]      wr_q;
    logic [W+LOG2_MAX-1:0]    sum_d;
    logic [2:0]               k_d;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (push_i) begin
            mem_q[wr_q] <= sample_i;
            wr_q        <= wr_q + 1'b1;
        end
    end

    // the depth is clipped, so a larger setting averages over all entries
    always_comb begin
        k_d   = (depth_log2_i > 3'(LOG2_MAX)) ? 3'(LOG2_MAX) : depth_log2_i;
        sum_d = '0;
        for (int i = 1; i <= DEPTH; i++) begin
            if (i <= (1 << k_d)) begin
                sum_d = sum_d + (W+LOG2_MAX)'(mem_q[LOG2_MAX'(wr_q - LOG2_MAX'(i))]);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mean_o <= '0;
        end else begin
            mean_o <= W'(sum_d >> k_d);
        end
    end
endmodule

// file: verif/elt_line_trigger_props.sv
`timescale 1ns/100ps
`include "elt_cfg.svh"
module elt_line_trigger_props (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // wishbone
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // encoder and trigger
    input wire logic        quad_channel_a_i,
    input wire logic        quad_channel_b_i,
    input wire logic        line_trigger_o,
    input wire logic        direction_o
);
    import elt_pkg::*;
    logic        a_q, b_q, sense_q, edge_q, wr_take, rd_take, chg, fwd_raw;
    logic [1:0]  pol_q;
    logic [15:0] pass_q;
    logic [15:0] wid_q;
    logic [7:0]  strobe_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    assign wr_take = cyc_i && stb_i && we_i && !ack_o;
    assign rd_take = cyc_i && stb_i && !we_i && !ack_o;
    assign chg     = (quad_channel_a_i != a_q) || (quad_channel_b_i != b_q);
    assign fwd_raw = quad_channel_a_i ^ b_q;
    always_ff @(posedge clk_i) begin
        a_q <= quad_channel_a_i;
        b_q <= quad_channel_b_i;
    end
    // shadow of the settings; lane 0 only, as the design honours for CTRL and STROBE (it writes PASS by lanes 0 and 1)
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {sense_q, pol_q, edge_q} <= 4'h0;
            pass_q <= 16'h0;
            strobe_q <= 8'h01;
        end else if (wr_take && sel_i[0]) begin
            if (adr_i == `ELT_OFS_CTRL) {sense_q, pol_q, edge_q} <= dat_i[3:0];
            if (adr_i == `ELT_OFS_PASS) pass_q <= dat_i[15:0];
            if (adr_i == `ELT_OFS_STROBE) strobe_q <= (dat_i[7:0] == 8'h0) ? 8'h01 : dat_i[7:0];
        end
    end
    always_ff @(posedge clk_i) begin
        wid_q <= line_trigger_o ? wid_q + 16'h1 : 16'h0;
    end
    sequence s_fwd_step;
        chg && fwd_raw;
    endsequence
    sequence s_rev_step;
        chg && !fwd_raw;
    endsequence
    a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_rd_unmapped: assert property (rd_take && adr_i >= 8'h20 |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_begin: assert property (rd_take && adr_i == `ELT_OFS_CTRL |=> !dat_o[4])
        else $error("capture begin bit reads back set");
    a_dat_hold: assert property (!rd_take |=> $stable(dat_o))
        else $error("read data moved without a read");
    a_dir_fwd: assert property (s_fwd_step |-> ##[1:4] direction_o == !sense_q)
        else $error("direction wrong after A leads");
    a_dir_rev: assert property (s_rev_step |-> ##[1:4] direction_o == sense_q)
        else $error("direction wrong after B leads");
    a_edge_trig: assert property (edge_q && pass_q == 16'h0 && pol_q == 2'h0 && chg
        |-> ##[1:4] line_trigger_o)
        else $error("edge without trigger");
    a_mask_rev: assert property (s_rev_step ##0 (edge_q && !sense_q && pol_q == 2'h1)
        |-> ##1 (!$rose(line_trigger_o))[*4])
        else $error("trigger during reverse travel");
    a_strobe_len: assert property ($fell(line_trigger_o)
        |-> wid_q >= {7'h0, strobe_q, 1'b0} - 16'h1)
        else $error("trigger strobe too short");
endmodule
bind elt_line_trigger elt_line_trigger_props u_props (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .quad_channel_a_i, .quad_channel_b_i, .line_trigger_o, .direction_o
);

// file: verif/elt_encoder_model.sv
`timescale 1ns/100ps
// quadrature encoder: one quarter step per request, levels hold while the shaft rests
module elt_encoder_model (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // motion request
    input  wire logic step_i,
    input  wire logic fwd_i,
    // encoder channels
    output logic      quad_channel_a_o,
    output logic      quad_channel_b_o
);
    logic [1:0] phase_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= 2'h0;
        end else if (step_i) begin
            phase_q <= fwd_i ? phase_q + 2'h1 : phase_q - 2'h1;
        end
    end
    // gray order, so only one channel moves per step and a quarter cycle separates them
    assign quad_channel_a_o = phase_q[1] ^ phase_q[0];
    assign quad_channel_b_o = phase_q[1];
endmodule

// file: verif/elt_line_trigger_tb.sv
`timescale 1ns/100ps
`include "elt_cfg.svh"
module elt_line_trigger_tb;
    logic        clk_i, rst_i, cyc, stb, we, step, fwd, qa, qb, trig, dir, ack, prev;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    int          n_mismatch, comparisons, ntrig, wid, lastw;
    elt_line_trigger dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .quad_channel_a_i(qa),
        .quad_channel_b_i(qb), .line_trigger_o(trig), .direction_o(dir)
    );
    elt_encoder_model enc_u (
        .clk_i(clk_i), .rst_i(rst_i), .step_i(step), .fwd_i(fwd),
        .quad_channel_a_o(qa), .quad_channel_b_o(qb)
    );
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // count rising edges and keep the width of the last strobe
    always @(posedge clk_i) begin
        prev <= trig;
        if (trig === 1'b1 && prev !== 1'b1) ntrig++;
        if (trig === 1'b1) wid++;
        else if (wid != 0) begin
            lastw = wid;
            wid = 0;
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 40);
        if (t == 40) n_mismatch++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(a, 1'b0, 32'h0);
        chk(nm, q, e);
    endtask
    // quarter steps spaced gap cycles apart; e below zero leaves the count to the caller
    task automatic run(input int n, input logic f, input int gap, input int e);
        ntrig = 0;
        repeat (n) begin
            step <= 1'b1;
            fwd <= f;
            @(posedge clk_i);
            step <= 1'b0;
            repeat (gap - 1) @(posedge clk_i);
        end
        repeat (12) @(posedge clk_i);
        if (e >= 0) chk("triggers", ntrig, e);
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (8000) @(posedge clk_i);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        {n_mismatch, comparisons, ntrig, wid, lastw} = '0;
        {rst_i, cyc, stb, we, step, fwd, adr, sel, wdat} = {1'b1, 49'h0};
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd("divider", `ELT_OFS_DIVIDER, 32'h0001_0000);
        rd("pass", `ELT_OFS_PASS, 32'h0);
        rd("strobe", `ELT_OFS_STROBE, 32'h1);
        rd("ctrl", `ELT_OFS_CTRL, 32'h0);
        rd("unmapped", 8'h20, 32'h0);
        run(32, 1'b1, 8, 8);
        wb(`ELT_OFS_DIVIDER, 1'b1, 32'h0002_0000);
        run(32, 1'b1, 8, 4);
        wb(`ELT_OFS_DIVIDER, 1'b1, 32'h0000_8000);
        run(32, 1'b1, 8, -1);
        chk("interp", 32'(ntrig >= 12 && ntrig <= 17), 32'h1);
        wb(`ELT_OFS_AVG, 1'b1, 32'h2);
        run(32, 1'b1, 8, -1);
        chk("average", 32'(ntrig >= 12 && ntrig <= 17), 32'h1);
        wb(`ELT_OFS_AVG, 1'b1, 32'h0);
        wb(`ELT_OFS_CTRL, 1'b1, 32'h1);
        run(32, 1'b1, 8, 32);
        wb(`ELT_OFS_PASS, 1'b1, 32'h2);
        run(24, 1'b1, 8, 8);
        wb(`ELT_OFS_PASS, 1'b1, 32'h0);
        run(8, 1'b0, 8, 8);
        chk("direction", {31'h0, dir}, 32'h0);
        wb(`ELT_OFS_CTRL, 1'b1, 32'h13);
        run(5, 1'b1, 8, 5);
        run(5, 1'b0, 8, 0);
        rd("maskcnt", `ELT_OFS_MASKCNT, 32'h5);
        run(5, 1'b1, 8, 0);
        rd("maskcnt", `ELT_OFS_MASKCNT, 32'h0);
        run(3, 1'b1, 8, 3);
        wb(`ELT_OFS_CTRL, 1'b1, 32'h5);
        run(3, 1'b1, 8, 0);
        rd("maskcnt", `ELT_OFS_MASKCNT, 32'h3);
        wb(`ELT_OFS_CTRL, 1'b1, 32'h15);
        rd("maskcnt", `ELT_OFS_MASKCNT, 32'h0);
        run(2, 1'b0, 8, 2);
        wb(`ELT_OFS_CTRL, 1'b1, 32'h1b);
        run(3, 1'b0, 8, 3);
        chk("direction", {31'h0, dir}, 32'h1);
        wb(`ELT_OFS_CTRL, 1'b1, 32'h1);
        wb(`ELT_OFS_STROBE, 1'b1, 32'h5);
        run(1, 1'b1, 30, 1);
        chk("strobe", 32'(lastw >= 9 && lastw <= 11), 32'h1);
        wb(`ELT_OFS_CTRL, 1'b1, 32'h0);
        wb(`ELT_OFS_MAXINT, 1'b1, 32'h20);
        rd("maxint", `ELT_OFS_MAXINT, 32'h20);
        repeat (400) @(posedge clk_i);
        // the long stop is clipped to 32 clocks, so the pulse still earns its second trigger
        run(4, 1'b1, 16, 2);
        tally_and_finish();
    end
endmodule
